// ---- logic/flash_host.sv ----
// flash host controller: sends command sequences and polls status
`timescale 1ns/10ps
// Overview of operation
// - first unlock writes aah to aaaah byte or 5555h word
// - second unlock writes 55h to 555h byte or 2aaah word
// - after reset during erase, host waits 10 us before reading
// - auto-select is unlock pair then 90h to aaaah or 5555h
// - program is unlock pair, a0h to the command address, target
module flash_host (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic byte_mode,
  input wire logic req_valid,
  input flash_host_pkg::request_t req,
  output logic req_ready,
  output logic ans_valid,
  output flash_host_pkg::answer_t ans,
  output flash_host_pkg::flash_pins_t pins,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic reset_unprotect_pin_n
);
  typedef enum logic [2:0] {
    s_idle, s_write, s_read, s_poll, s_settle, s_done
  } host_state_t;
  host_state_t state, next_state;
  flash_host_pkg::request_t cur, next_cur;
  logic [2:0] step, next_step;
  logic [15:0] last, next_last;
  logic [15:0] wait_cnt, next_wait_cnt;
  logic next_req_ready, next_ans_valid;
  flash_host_pkg::answer_t next_ans;
  logic cyc_start, next_cyc_start, cyc_write, next_cyc_write;
  logic [19:0] cyc_addr, next_cyc_addr;
  logic [15:0] cyc_wdata, next_cyc_wdata;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [19:0] a1, a2;
  logic toggling;

  flash_cycle u_cycle (
    .mclk(mclk),
    .rstn(rstn),
    .start(cyc_start),
    .write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .dq_in(dq_in),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(pins),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

  // ---------------------------------------------------------------
  // command sequence helpers
  // ---------------------------------------------------------------
  // unlock addresses depend on organisation
  assign a1 = byte_mode ? flash_host_pkg::byte_addr1
                        : flash_host_pkg::word_addr1;
  assign a2 = byte_mode ? flash_host_pkg::byte_addr2
                        : flash_host_pkg::word_addr2;
  // toggle flag differing between two reads means still busy
  assign toggling = (last[flash_host_pkg::toggle_flag_bit]
                     != cyc_rdata[flash_host_pkg::toggle_flag_bit]);

  // ---------------------------------------------------------------
  // main sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_step = step;
    next_last = last;
    next_wait_cnt = wait_cnt;
    next_req_ready = 1'b0;
    next_ans_valid = 1'b0;
    next_ans = ans;
    next_cyc_start = 1'b0;
    next_cyc_write = cyc_write;
    next_cyc_addr = cyc_addr;
    next_cyc_wdata = cyc_wdata;
    unique case (state)
      s_idle: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_req_ready = 1'b0;
          next_cur = req;
          next_step = 3'd0;
          next_ans = '0;
          if (req.op == flash_host_pkg::op_read ||
              req.op == flash_host_pkg::op_status) begin
            next_cyc_write = 1'b0;
            next_cyc_addr = req.addr;
            next_cyc_start = 1'b1;
            next_state = s_read;
          end else begin
            next_state = s_write;
            next_cyc_start = 1'b1;
            next_cyc_write = 1'b1;
            // first unlock opens every command sequence
            next_cyc_addr = a1;
            next_cyc_wdata = {8'h00, flash_host_pkg::unlock1_data};
          end
        end
      end
      s_write: begin
        if (cyc_done) begin
          next_step = step + 3'd1;
          next_cyc_start = 1'b1;
          unique case (step)
            3'd0: begin
              // second unlock follows the first directly
              next_cyc_addr = a2;
              next_cyc_wdata = {8'h00, flash_host_pkg::unlock2_data};
            end
            3'd1: begin
              next_cyc_addr = a1;
              unique case (cur.op)
                flash_host_pkg::op_reset:
                  // unlocked read/reset returns to array read
                  next_cyc_wdata = {8'h00, flash_host_pkg::read_reset_code};
                flash_host_pkg::op_auto_select:
                  next_cyc_wdata = {8'h00, flash_host_pkg::auto_select_code};
                default:
                  next_cyc_wdata = {8'h00, flash_host_pkg::program_code};
              endcase
            end
            3'd2: begin
              if (cur.op == flash_host_pkg::op_program) begin
                // target write; device latches address then data
                next_cyc_addr = cur.addr;
                next_cyc_wdata = cur.data;
              end else if (cur.op == flash_host_pkg::op_reset) begin
                // reads may be stale while an erase winds down
                next_cyc_start = 1'b0;
                next_wait_cnt = 16'(flash_host_pkg::settle_cyc);
                next_state = s_settle;
              end else begin
                next_cyc_start = 1'b0;
                next_state = s_done;
              end
            end
            default: begin
              // program launched: poll status until steady
              next_cyc_write = 1'b0;
              next_cyc_addr = cur.addr;
              next_wait_cnt = 16'h0000;
              next_state = s_poll;
            end
          endcase
        end
      end
      s_poll: begin
        if (cyc_done) begin
          next_last = cyc_rdata;
          next_wait_cnt = wait_cnt + 16'h0001;
          if (wait_cnt != 16'h0000 && !toggling) begin
            // toggling stopped, so the operation ended well
            next_ans.data = cyc_rdata;
            next_ans.error = 1'b0;
            next_state = s_done;
          end else if (wait_cnt != 16'h0000 && ans.error) begin
            // still toggling one read after the error flag: failed
            next_ans.data = cyc_rdata;
            next_state = s_done;
          end else if (wait_cnt != 16'h0000 &&
                       cyc_rdata[flash_host_pkg::error_flag_bit]) begin
            // error flag seen while busy: one more read decides
            next_ans.error = 1'b1;
            next_cyc_start = 1'b1;
          end else if (wait_cnt == 16'(flash_host_pkg::poll_limit)) begin
            next_ans.timeout = 1'b1;
            next_state = s_done;
          end else begin
            next_cyc_start = 1'b1;
          end
        end
      end
      s_settle: begin
        if (wait_cnt != 16'h0000) begin
          next_wait_cnt = wait_cnt - 16'h0001;
        end else begin
          next_state = s_done;
        end
      end
      s_read: begin
        if (cyc_done) begin
          next_ans.data = cyc_rdata;
          // an unexpected one over a zero would report through the flag
          next_ans.error = cur.op == flash_host_pkg::op_status &&
                           cyc_rdata[flash_host_pkg::error_flag_bit];
          next_state = s_done;
        end
      end
      s_done: begin
        next_ans_valid = 1'b1;
        next_state = s_idle;
      end
      default: next_state = s_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= s_idle;
      cur <= '0;
      step <= 3'd0;
      last <= 16'h0000;
      wait_cnt <= 16'h0000;
      req_ready <= 1'b0;
      ans_valid <= 1'b0;
      ans <= '0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= 20'h00000;
      cyc_wdata <= 16'h0000;
      reset_unprotect_pin_n <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      step <= next_step;
      last <= next_last;
      wait_cnt <= next_wait_cnt;
      req_ready <= next_req_ready;
      ans_valid <= next_ans_valid;
      ans <= next_ans;
      cyc_start <= next_cyc_start;
      cyc_write <= next_cyc_write;
      cyc_addr <= next_cyc_addr;
      cyc_wdata <= next_cyc_wdata;
      // device held in reset while the controller is, then released
      reset_unprotect_pin_n <= 1'b1;
    end
  end
endmodule

// ---- logic/flash_host_pkg.sv ----
// package: constants and carrier types for the flash host controller
package flash_host_pkg;
  // command codes and unlock addresses
  localparam logic [7:0] unlock1_data = 8'haa;
  localparam logic [7:0] unlock2_data = 8'h55;
  localparam logic [7:0] read_reset_code = 8'hf0;
  localparam logic [7:0] auto_select_code = 8'h90;
  localparam logic [7:0] program_code = 8'ha0;
  localparam logic [19:0] byte_addr1 = 20'h0aaaa;
  localparam logic [19:0] byte_addr2 = 20'h00555;
  localparam logic [19:0] word_addr1 = 20'h05555;
  localparam logic [19:0] word_addr2 = 20'h02aaa;
  // status flag positions in the data read back
  localparam int polling_flag_bit = 7;
  localparam int toggle_flag_bit = 6;
  localparam int error_flag_bit = 5;
  localparam int erase_timer_flag_bit = 3;
  localparam int erase_toggle_flag_bit = 2;
  // auto-select offsets on address bits 1:0
  localparam logic [1:0] as_maker_off = 2'h0;
  localparam logic [1:0] as_device_off = 2'h1;
  localparam logic [1:0] as_protect_off = 2'h2;
  localparam int block_sel_lsb = 12;
  // bus strobe timing, reset settle and poll limit
  localparam int clk_ns = 10;
  localparam int strobe_ns = 50;
  localparam int strobe_cyc = (strobe_ns + clk_ns - 1) / clk_ns;
  localparam int settle_us = 10;
  localparam int settle_cyc = settle_us * 1000 / clk_ns;
  localparam int poll_limit = 4096;

  typedef enum logic [2:0] {
    op_read, op_reset, op_auto_select, op_program, op_status
  } op_t;

  typedef struct packed {
    op_t op;
    logic [19:0] addr;
    logic [15:0] data;
  } request_t;

  typedef struct packed {
    logic [15:0] data;
    logic error;
    logic timeout;
  } answer_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [19:0] addr;
  } flash_pins_t;
endpackage

// ---- logic/flash_cycle.sv ----
// single bus cycle engine: one write or read strobe on the flash pins
`timescale 1ns/10ps
module flash_cycle (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire logic write,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output logic done,
  output logic [15:0] rdata,
  output flash_host_pkg::flash_pins_t pins,
  output logic [15:0] dq_out,
  output logic dq_oe
);
  typedef enum logic [1:0] {idle, setup, strobe, hold} cyc_state_t;
  cyc_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic next_done;
  logic [15:0] next_rdata, next_dq_out;
  logic next_dq_oe;
  flash_host_pkg::flash_pins_t next_pins;
  logic [15:0] sync1, sync2, sync3;

  // ---------------------------------------------------------------
  // read data synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
      sync3 <= 16'h0000;
    end else begin
      sync1 <= dq_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ---------------------------------------------------------------
  // strobe sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_done = 1'b0;
    next_rdata = rdata;
    next_pins = pins;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    unique case (state)
      idle: begin
        if (start) begin
          // address settles before the strobe falls
          next_pins.addr = addr;
          next_pins.ce_n = 1'b0;
          next_dq_out = wdata;
          next_dq_oe = write;
          next_cnt = 8'(flash_host_pkg::strobe_cyc);
          next_state = setup;
        end
      end
      setup: begin
        next_pins.we_n = !write;
        next_pins.oe_n = write;
        next_state = strobe;
      end
      strobe: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else begin
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_state = hold;
        end
      end
      hold: begin
        // sync3 lags the pins by three edges, the strobe window covers it
        if (sync2 == sync3 && !write) begin
          next_rdata = sync3;
        end
        next_pins.ce_n = 1'b1;
        next_dq_oe = 1'b0;
        next_done = 1'b1;
        next_state = idle;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= idle;
      cnt <= 8'h00;
      done <= 1'b0;
      rdata <= 16'h0000;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h00000};
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      done <= next_done;
      rdata <= next_rdata;
      pins <= next_pins;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
    end
  end
endmodule

// ---- sim/flash_host_props.sv ----
// checker: bus strobe and command order properties of the flash host
`timescale 1ns/10ps
module flash_host_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic byte_mode,
  input wire logic req_valid,
  input flash_host_pkg::request_t req,
  input wire logic req_ready,
  input flash_host_pkg::flash_pins_t pins,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe
);
  // ------
  // helpers
  // ------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic we_q;
  logic [1:0] wcnt;
  flash_host_pkg::request_t cur;
  logic fall, wr_op;
  logic [15:0] a1, a2;
  logic [7:0] code;
  assign fall = we_q && !pins.we_n;
  assign wr_op = cur.op inside {flash_host_pkg::op_reset,
    flash_host_pkg::op_auto_select, flash_host_pkg::op_program};
  assign a1 = byte_mode ? flash_host_pkg::byte_addr1[15:0] :
    flash_host_pkg::word_addr1[15:0];
  assign a2 = byte_mode ? flash_host_pkg::byte_addr2[15:0] :
    flash_host_pkg::word_addr2[15:0];
  assign code = (cur.op == flash_host_pkg::op_reset) ? 8'hf0 :
    (cur.op == flash_host_pkg::op_program) ? 8'ha0 : 8'h90;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      we_q <= 1'h1;
      wcnt <= 2'h0;
      cur <= '0;
    end else begin
      we_q <= pins.we_n;
      if (req_valid && req_ready) begin
        wcnt <= 2'h0;
        cur <= req;
      end else if (fall) begin
        wcnt <= wcnt + 2'h1;
      end
    end
  end
  // ------
  // properties
  // ------
  property p_unlock1;
    fall && wcnt == 2'h0 && wr_op |->
      dq_out[7:0] == 8'haa && pins.addr[15:0] == a1;
  endproperty
  a_unlock1: assert property (p_unlock1)
    else $error("bad first unlock");
  property p_unlock2;
    fall && wcnt == 2'h1 && wr_op |->
      dq_out[7:0] == 8'h55 && pins.addr[15:0] == a2;
  endproperty
  a_unlock2: assert property (p_unlock2)
    else $error("bad second unlock");
  property p_command;
    fall && wcnt == 2'h2 && wr_op |-> dq_out[7:0] == code &&
      (cur.op == flash_host_pkg::op_reset || pins.addr[15:0] == a1);
  endproperty
  a_command: assert property (p_command) else $error("bad command");
  property p_target;
    fall && wcnt == 2'h3 && cur.op == flash_host_pkg::op_program |->
      pins.addr == cur.addr && dq_out == cur.data;
  endproperty
  a_target: assert property (p_target)
    else $error("bad target write");
  property p_read_only;
    fall |-> wr_op;
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("stray write");
  property p_excl;
    !(!pins.we_n && !pins.oe_n);
  endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_we_held;
    fall |-> (!pins.we_n && !pins.ce_n && dq_oe &&
      $stable(pins.addr) && $stable(dq_out))[*5];
  endproperty
  a_we_held: assert property (p_we_held)
    else $error("write unstable");
  property p_read_float;
    !pins.oe_n |-> !dq_oe && !pins.ce_n;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("read drives");
endmodule
bind flash_host flash_host_props u_flash_host_props (.mclk(mclk),
  .rstn(rstn), .byte_mode(byte_mode), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe));

// ---- sim/flash_dev_model.sv ----
// behavioural model of the flash device facing the host controller
`timescale 1ns/10ps
module flash_dev_model #(
  parameter logic [7:0] maker_code = 8'h3c, // arbitrary value
  parameter logic [7:0] device_code = 8'h5a, // arbitrary value
  parameter logic [6:0] locked_blk = 7'h05
) (
  input wire logic byte_mode,
  input flash_host_pkg::flash_pins_t pins,
  input wire logic [15:0] dq_out,
  input wire logic reset_unprotect_pin_n,
  output logic [15:0] dq_in
);
  logic [15:0] mem [16];
  logic [15:0] rd, gone, pd;
  logic [19:0] wa;
  logic [1:0] mode;
  logic tog, err, drv, hit1, hit2;
  int step, busy;
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    mode = 2'h0;
    step = 0;
    tog = 1'h0;
    err = 1'h0;
    drv = 1'h0;
    gone = 16'h5a5a;
    rd = 16'h0;
    pd = 16'h0;
  end
  // only the low sixteen address lines take part in unlock decode
  assign hit1 = wa[15:0] == (byte_mode ? flash_host_pkg::byte_addr1[15:0] :
    flash_host_pkg::word_addr1[15:0]);
  assign hit2 = wa[15:0] == (byte_mode ? flash_host_pkg::byte_addr2[15:0] :
    flash_host_pkg::word_addr2[15:0]);
  // a released bus shows the inverse of the last value, never a hold
  assign dq_in = drv ? rd : gone;
  always @(negedge pins.we_n) if (!pins.ce_n) wa = pins.addr;
  // writes are ignored while a good program runs; a failed one waits reset
  always @(posedge pins.we_n) if (!pins.ce_n && (mode != 2'h2 || err)) begin
    case (step)
      0: if (dq_out[7:0] == 8'haa && hit1) step = 1;
        else if (dq_out[7:0] == 8'hf0) begin
          mode = 2'h0;
          err = 1'h0;
        end
      1: step = (dq_out[7:0] == 8'h55 && hit2) ? 2 : 0;
      2: begin
        step = 0;
        case (dq_out[7:0])
          8'hf0: begin mode = 2'h0; err = 1'h0; end
          8'h90: if (hit1) mode = 2'h1;
          8'ha0: if (hit1) step = 3;
          default: mode = 2'h0;
        endcase
      end
      default: begin
        step = 0;
        pd = dq_out;
        err = |(dq_out & ~mem[wa[3:0]]);
        mem[wa[3:0]] = mem[wa[3:0]] & dq_out;
        mode = 2'h2;
        busy = 3;
      end
    endcase
  end
  always @(negedge pins.oe_n) if (!pins.ce_n) begin
    if (mode == 2'h2) begin
      tog = ~tog;
      // no block is ever erasing here: erase toggle flag one, timer idle
      // high
      rd = {8'h0, ~pd[7], tog, err, 3'h3, 2'h0};
      busy = busy - 1;
      if (!err && busy == 0) mode = 2'h0;
    end else if (mode == 2'h1) begin
      case (pins.addr[1:0])
        2'h0: rd = {8'h0, maker_code};
        2'h1: rd = {8'h0, device_code};
        2'h2: rd = {15'h0, pins.addr[18:12] == locked_blk};
        default: rd = 16'h0;
      endcase
    end else rd = mem[pins.addr[3:0]];
    drv = 1'h1;
  end
  always @(posedge pins.oe_n) begin
    drv = 1'h0;
    gone = ~rd;
  end
  always @(negedge reset_unprotect_pin_n) begin
    mode = 2'h0;
    step = 0;
  end
endmodule

// ---- sim/flash_host_test.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/10ps
module flash_host_test;
  logic mclk, rstn, byte_mode, req_valid, req_ready, ans_valid, dq_oe, rp_n;
  flash_host_pkg::request_t req;
  flash_host_pkg::answer_t ans, got;
  flash_host_pkg::flash_pins_t pins;
  logic [15:0] dq_in, dq_out;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  flash_host u_flash_host (.mclk(mclk), .rstn(rstn), .byte_mode(byte_mode),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .ans_valid(ans_valid), .ans(ans), .pins(pins), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .reset_unprotect_pin_n(rp_n));
  flash_dev_model u_flash_dev_model (.byte_mode(byte_mode), .pins(pins),
    .dq_out(dq_out), .reset_unprotect_pin_n(rp_n), .dq_in(dq_in));
  // ------
  // shared tasks
  // ------
  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // reset requests carry a long settle, so the waits are generous
  task automatic do_req(input flash_host_pkg::op_t op,
    input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'h1 && n < 30000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 30000) n_mismatch++;
    req = '{op: op, addr: a, data: d};
    req_valid = 1'h1;
    @(posedge mclk); #1;
    req_valid = 1'h0;
    n = 0;
    while (ans_valid !== 1'h1 && n < 30000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 30000) n_mismatch++;
    got = ans;
  endtask
  // ------
  // scenarios
  // ------
  task t_autosel();
    byte_mode = 1'h0;
    do_req(flash_host_pkg::op_auto_select, 20'h0, 16'h0);
    do_req(flash_host_pkg::op_read, 20'h00000, 16'h0);
    check(got.data, 16'h003c);
    do_req(flash_host_pkg::op_read, 20'h00001, 16'h0);
    check(got.data, 16'h005a);
    do_req(flash_host_pkg::op_read, 20'h05002, 16'h0);
    check(got.data, 16'h0001);
    do_req(flash_host_pkg::op_read, 20'h06002, 16'h0);
    check(got.data, 16'h0000);
    do_req(flash_host_pkg::op_reset, 20'h0, 16'h0);
    do_req(flash_host_pkg::op_read, 20'h00004, 16'h0);
    check(got.data, 16'hffff);
    byte_mode = 1'h1;
    do_req(flash_host_pkg::op_auto_select, 20'h0, 16'h0);
    do_req(flash_host_pkg::op_read, 20'h00000, 16'h0);
    check({8'h0, got.data[7:0]}, 16'h003c);
    byte_mode = 1'h0;
    do_req(flash_host_pkg::op_reset, 20'h0, 16'h0);
    $display("t_autosel done");
  endtask
  task t_program();
    do_req(flash_host_pkg::op_program, 20'h00003, 16'h00f0);
    check({14'h0, got.error, got.timeout}, 16'h0000);
    do_req(flash_host_pkg::op_read, 20'h00003, 16'h0);
    check(got.data, 16'h00f0);
    do_req(flash_host_pkg::op_program, 20'h00003, 16'h0ff0);
    check({15'h0, got.error}, 16'h0001);
    do_req(flash_host_pkg::op_reset, 20'h0, 16'h0);
    do_req(flash_host_pkg::op_read, 20'h00003, 16'h0);
    check(got.data, 16'h00f0);
    do_req(flash_host_pkg::op_program, 20'h00005, 16'h1234);
    check({15'h0, got.error}, 16'h0000);
    do_req(flash_host_pkg::op_status, 20'h00005, 16'h0);
    check(got.data, 16'h1234);
    $display("t_program done");
  endtask
  // ------
  // clock, watchdog and main sequence
  // ------
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    rstn = 1'h0;
    byte_mode = 1'h0;
    req_valid = 1'h0;
    req = '0;
    repeat (6) @(posedge mclk);
    #1;
    rstn = 1'h1;
    t_autosel();
    t_program();
    stop_test();
  end
endmodule
